// [fault_guard_pkg.sv]
// shared constants, modes and carriers for the fault log access guard
package fault_guard_pkg;
  // instruction codes seen as the first byte of an i2c write
  localparam logic [7:0] OP_UNLOCK = 8'h74;
  localparam logic [7:0] OP_STATUS = 8'h03;
  localparam logic [7:0] OP_READ_ALL = 8'h76;
  localparam logic [7:0] OP_PROGRAM = 8'h04;
  localparam logic [7:0] OP_ERASE = 8'h71;
  localparam logic [7:0] OP_USER = 8'h05;
  // configuration writers covered by write protection
  localparam logic [7:0] OP_CFG_WRITE = 8'h10;
  localparam logic [7:0] OP_CFG_MASKED = 8'h11;
  localparam logic [7:0] OP_TRIM_SET = 8'h12;
  // keys
  localparam logic [7:0] KEY_UNLOCK = 8'hac;
  localparam logic [7:0] KEY_PROG_HI = 8'he5;
  localparam logic [7:0] KEY_PROG_LO = 8'h3d;
  // fault log status values: request field b7..b6, grant field b5..b4
  localparam logic [7:0] STAT_RECORDING = 8'h00;
  localparam logic [7:0] STAT_REQUESTED = 8'hc0;
  localparam logic [7:0] STAT_ENABLED = 8'hf0;
  // monitor status low layout
  localparam int MON_COUNT_LSB = 4;
  localparam int MON_FULL_BIT = 3;
  // record geometry
  localparam logic [2:0] REC_LAST_BYTE = 3'h6;
  localparam logic [3:0] REC_LAST = 4'hf;
  // readout buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  // write protection modes, fixed at initial programming
  localparam logic [1:0] PROT_OPEN = 2'h0;
  localparam logic [1:0] PROT_LOCKED = 2'h1;
  localparam logic [1:0] PROT_PIN = 2'h2;
  // reset values
  localparam logic [7:0] TX_RESET = 8'h00;

  // byte-level events from the i2c slave engine, same clock
  typedef struct packed {
    logic start;     // start or repeated start
    logic stop;      // stop seen
    logic wrValid;   // one write byte received
    logic [7:0] wrData;
    logic rdReq;     // master wants the next read byte
    logic rdNack;    // master nacked the last read byte
  } i2c_evt_t;

  // address of one byte of the non-volatile log
  typedef struct packed {
    logic [3:0] record;
    logic [2:0] index;
  } log_addr_t;
endpackage

// [readout_fifo.sv]
// parameterised valid/ready fifo for the readout stream
module readout_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;         // one extra bit tells full from empty
  logic push;
  logic pop;

  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop) rdPtr_reg <= rdPtr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [fault_log_guard.sv]
// instruction control for fault log readout, erase and config write guard
module fault_log_guard (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // byte engine of the i2c slave
  input wire fault_guard_pkg::i2c_evt_t i2cEvt,
  output logic txValid,
  output logic [7:0] txData,
  output logic wrAck,
  // fault recorder and its memory
  input wire logic [3:0] recordCount,
  input wire logic logFull,
  input wire logic recorderBusy,
  input wire logic eraseBusy,
  input wire logic [7:0] memData,
  output logic memRdEn,
  output fault_guard_pkg::log_addr_t memAddr,
  output logic recordHold,
  output logic eraseStart,
  // modes and protection
  input wire logic faultLogMode,
  input wire logic [1:0] protMode,
  input wire logic writePermitPin,
  output logic progModeActive,
  // configuration write path
  output logic cfgWrStrobe,
  output logic [7:0] cfgWrOp,
  output logic [7:0] cfgWrData
);
  typedef enum logic [1:0] {LOG_RECORDING, LOG_REQUESTED, LOG_ENABLED} log_state_t;
  typedef enum logic [2:0] {P_OPCODE, P_UNLOCK_KEY, P_PROG_HI, P_PROG_LO, P_CFG_DATA,
                            P_DISCARD} parse_state_t;

  log_state_t logState_reg;     // unlock handshake state
  parse_state_t parse_reg;      // write byte parser
  logic [7:0] lastOp_reg;       // opcode that a following read answers
  logic permitMeta_reg;         // first stage, read only by the second
  logic permitSync_reg;
  logic streamOn_reg;           // bulk readout fetch running
  logic fetchDone_reg;          // last byte of record 15 requested
  logic pend_reg;               // memory data arrives this cycle
  logic rdWait_reg;             // host read waiting on the buffer
  logic cfgAllowed;
  logic opcodeByte;
  logic unlockGood;
  logic unlockBad;
  logic gatedOp;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic streamRead;
  logic popNow;
  logic flushNow;
  logic issue;
  logic [7:0] statusByte;
  logic [7:0] monitorByte;
  // decoded write events
  assign opcodeByte = i2cEvt.wrValid && (parse_reg == P_OPCODE);
  assign unlockGood = i2cEvt.wrValid && (parse_reg == P_UNLOCK_KEY)
                      && (i2cEvt.wrData == fault_guard_pkg::KEY_UNLOCK);
  assign unlockBad = i2cEvt.wrValid && (parse_reg == P_UNLOCK_KEY)
                     && (i2cEvt.wrData != fault_guard_pkg::KEY_UNLOCK);
  assign gatedOp = (i2cEvt.wrData == fault_guard_pkg::OP_UNLOCK)
                   || (i2cEvt.wrData == fault_guard_pkg::OP_READ_ALL)
                   || (i2cEvt.wrData == fault_guard_pkg::OP_ERASE);

  assign cfgAllowed = (protMode == fault_guard_pkg::PROT_OPEN)
                      || ((protMode == fault_guard_pkg::PROT_PIN) && permitSync_reg);

  // status byte with low nibble zero
  always_comb begin
    unique case (logState_reg)
      LOG_RECORDING: statusByte = fault_guard_pkg::STAT_RECORDING;
      LOG_REQUESTED: statusByte = fault_guard_pkg::STAT_REQUESTED;
      LOG_ENABLED: statusByte = eraseBusy ? fault_guard_pkg::STAT_RECORDING
                                          : fault_guard_pkg::STAT_ENABLED;
      default: statusByte = fault_guard_pkg::STAT_RECORDING;  // spare code reads as recording
    endcase
  end

  // record count in the high nibble, full flag below it
  always_comb begin
    monitorByte = '0;
    monitorByte[fault_guard_pkg::MON_COUNT_LSB +: 4] = recordCount;
    monitorByte[fault_guard_pkg::MON_FULL_BIT] = logFull;
  end

  // permit pin is asynchronous, two flops before use
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      permitMeta_reg <= 1'b0;
      permitSync_reg <= 1'b0;
    end else begin
      permitMeta_reg <= writePermitPin;
      permitSync_reg <= permitMeta_reg;
    end
  end

  // write byte parser; a start always rearms for a new opcode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      parse_reg <= P_OPCODE;
      lastOp_reg <= '0;
    end else if (i2cEvt.start || i2cEvt.stop) begin
      parse_reg <= P_OPCODE;
    end else if (opcodeByte) begin
      lastOp_reg <= i2cEvt.wrData;
      // unlock, readout and erase ignored outside fault logging mode
      if (gatedOp && !faultLogMode) begin
        parse_reg <= P_DISCARD;
        lastOp_reg <= '0;
      end else if (i2cEvt.wrData == fault_guard_pkg::OP_UNLOCK) begin
        parse_reg <= P_UNLOCK_KEY;
      end else if (i2cEvt.wrData == fault_guard_pkg::OP_PROGRAM) begin
        parse_reg <= P_PROG_HI;
      end else if ((i2cEvt.wrData == fault_guard_pkg::OP_CFG_WRITE)
                   || (i2cEvt.wrData == fault_guard_pkg::OP_CFG_MASKED)
                   || (i2cEvt.wrData == fault_guard_pkg::OP_TRIM_SET)) begin
        parse_reg <= P_CFG_DATA;
      end else begin
        parse_reg <= P_DISCARD;
      end
    end else if (i2cEvt.wrValid) begin
      unique case (parse_reg)
        P_PROG_HI: parse_reg <= (i2cEvt.wrData == fault_guard_pkg::KEY_PROG_HI)
                                ? P_PROG_LO : P_DISCARD;
        P_CFG_DATA: parse_reg <= P_CFG_DATA;
        default: parse_reg <= P_DISCARD;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      logState_reg <= LOG_RECORDING;
      recordHold <= 1'b0;
    end else if (unlockBad) begin
      logState_reg <= LOG_RECORDING;
      recordHold <= 1'b0;
    end else if (unlockGood) begin
      logState_reg <= (logState_reg == LOG_ENABLED) ? LOG_ENABLED : LOG_REQUESTED;
      recordHold <= 1'b1;
    end else if (logState_reg == LOG_REQUESTED && !recorderBusy && !eraseBusy) begin
      // grant once neither the recorder nor an erase is busy
      logState_reg <= LOG_ENABLED;
    end
  end

  // program mode entry, exit to user mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      progModeActive <= 1'b0;
    end else if (opcodeByte && i2cEvt.wrData == fault_guard_pkg::OP_USER) begin
      progModeActive <= 1'b0;
    end else if (i2cEvt.wrValid && parse_reg == P_PROG_LO
                 && i2cEvt.wrData == fault_guard_pkg::KEY_PROG_LO) begin
      progModeActive <= 1'b1;
    end
  end

  // erase pulse; nvm change needs program mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      eraseStart <= 1'b0;
    end else begin
      eraseStart <= opcodeByte && faultLogMode && progModeActive
                    && (logState_reg == LOG_ENABLED)
                    && (i2cEvt.wrData == fault_guard_pkg::OP_ERASE);
    end
  end

  // every write byte acked; only config bytes are gated
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrAck <= 1'b0;
      cfgWrStrobe <= 1'b0;
      cfgWrOp <= '0;
      cfgWrData <= '0;
    end else begin
      wrAck <= i2cEvt.wrValid;
      cfgWrStrobe <= i2cEvt.wrValid && (parse_reg == P_CFG_DATA) && cfgAllowed;
      if (i2cEvt.wrValid && parse_reg == P_CFG_DATA) begin
        cfgWrOp <= lastOp_reg;
        cfgWrData <= i2cEvt.wrData;
      end
    end
  end

  // bulk readout runs until stop; data is discarded on stop
  assign flushNow = i2cEvt.stop;
  assign issue = streamOn_reg && !fetchDone_reg && !memRdEn && !pend_reg && fifoInReady;

  // fetch starts at record 0 byte 0
  always_ff @(posedge mclk) begin
    if (!rst_n || flushNow) begin
      streamOn_reg <= 1'b0;
      fetchDone_reg <= 1'b0;
      memRdEn <= 1'b0;
      pend_reg <= 1'b0;
      memAddr <= '0;
    end else begin
      if (opcodeByte && faultLogMode && logState_reg == LOG_ENABLED
          && i2cEvt.wrData == fault_guard_pkg::OP_READ_ALL) begin
        streamOn_reg <= 1'b1;
        fetchDone_reg <= 1'b0;
        memAddr <= '0;
      end
      memRdEn <= issue;
      pend_reg <= memRdEn;
      // advance byte then record once the read is out
      if (memRdEn) begin
        if (memAddr.index == fault_guard_pkg::REC_LAST_BYTE) begin
          memAddr.index <= '0;
          if (memAddr.record == fault_guard_pkg::REC_LAST) begin
            fetchDone_reg <= 1'b1;
          end else begin
            memAddr.record <= memAddr.record + 1'b1;
          end
        end else begin
          memAddr.index <= memAddr.index + 1'b1;
        end
      end
    end
  end

  // buffer fills from memory, drains only on host reads, so it stalls the fetch
  readout_fifo #(
    .WIDTH(fault_guard_pkg::FIFO_WIDTH),
    .DEPTH(fault_guard_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .flush(flushNow),
    .inValid(pend_reg),
    .inReady(fifoInReady),
    .inData(memData),
    .outValid(fifoOutValid),
    .outReady(popNow),
    .outData(fifoOutData)
  );

  assign streamRead = (lastOp_reg == fault_guard_pkg::OP_READ_ALL) && streamOn_reg;
  assign popNow = streamRead && fifoOutValid && (i2cEvt.rdReq || rdWait_reg);

  // read answers: status, monitor byte or stream data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txValid <= 1'b0;
      txData <= fault_guard_pkg::TX_RESET;
      rdWait_reg <= 1'b0;
    end else begin
      txValid <= 1'b0;
      if (flushNow || i2cEvt.rdNack) begin
        rdWait_reg <= 1'b0;
      end else if (streamRead && (i2cEvt.rdReq || rdWait_reg)) begin
        // an empty buffer holds the request until data lands
        rdWait_reg <= !fifoOutValid;
        if (fifoOutValid) begin
          txValid <= 1'b1;
          txData <= fifoOutData;
        end
      end else if (i2cEvt.rdReq) begin
        txValid <= 1'b1;
        unique case (lastOp_reg)
          fault_guard_pkg::OP_UNLOCK: txData <= statusByte;
          fault_guard_pkg::OP_STATUS: txData <= monitorByte;
          default: txData <= fault_guard_pkg::TX_RESET;
        endcase
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_unlock_key;
    unlockGood && !i2cEvt.start && !i2cEvt.stop;
  endsequence
  sequence s_status_read;
    i2cEvt.rdReq && lastOp_reg == fault_guard_pkg::OP_STATUS && !i2cEvt.rdNack
      && !i2cEvt.stop;
  endsequence

  a_unlock_holds: assert property (s_unlock_key |=> recordHold && logState_reg != LOG_RECORDING)
    else $error("unlock key did not stop recording");
  a_grant_status: assert property ((logState_reg == LOG_ENABLED && !eraseBusy)
                                   |-> recordHold && statusByte == 8'hf0)
    else $error("enabled state without 0xf0 and hold");
  a_count_reply: assert property (s_status_read |=> txValid
                                  && txData[7:4] == $past(recordCount))
    else $error("status read lacks record count");
  a_full_reply: assert property (s_status_read |=> txData[3] == $past(logFull)
                                 && txData[2:0] == 3'h0)
    else $error("log full bit wrong");
  a_stream_origin: assert property ((streamOn_reg && !$past(streamOn_reg)) |-> memAddr == '0)
    else $error("readout did not begin at record 0 byte 0");
  a_relock_key: assert property (unlockBad |=> !recordHold ##1 statusByte == 8'h00)
    else $error("wrong key left recording stopped");
  a_mode_gate: assert property ((opcodeByte && !faultLogMode) |=> !eraseStart && !$rose(streamOn_reg))
    else $error("readout or erase outside logging mode");
  a_erase_needs: assert property (eraseStart |-> $past(progModeActive)
                                  && $past(logState_reg) == LOG_ENABLED)
    else $error("erase without program mode and unlock");
  a_user_exit: assert property ((opcodeByte && i2cEvt.wrData == fault_guard_pkg::OP_USER)
                                |=> !progModeActive)
    else $error("user instruction left program mode on");
  a_protect_gate: assert property (cfgWrStrobe |-> $past(protMode) != fault_guard_pkg::PROT_LOCKED)
    else $error("config write passed a locked device");
  a_ack_always: assert property (i2cEvt.wrValid |=> wrAck)
    else $error("write byte not acked");
  a_record_step: assert property ((memRdEn && memAddr.index == 3'h6 && memAddr.record != 4'hf
                                   && !flushNow)
                                  |=> memAddr.index == 3'h0
                                      && memAddr.record == $past(memAddr.record) + 4'h1)
    else $error("record address did not advance");
endmodule

// [log_mem_model.sv]
// stand-in for the fault log memory behind the guard's read port
module log_mem_model (
  // clock
  input wire logic mclk,
  // read port driven by the guard
  input wire logic memRdEn,
  input wire fault_guard_pkg::log_addr_t memAddr,
  output logic [7:0] memData
);
  timeunit 1ns;
  timeprecision 1ps;

  // known start value so the toggling below is never stuck at unknown
  initial memData = 8'h00;

  // byte is valid only in the cycle after its read strobe
  // between reads the line toggles so stale data cannot pass for a match
  always @(posedge mclk) begin
    if (memRdEn === 1'b1) begin
      memData <= {1'b0, memAddr} ^ 8'h5a;
    end else begin
      memData <= ~memData;
    end
  end
endmodule

// [tb.sv]
// self-checking bench for the fault log access guard
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and byte events
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  fault_guard_pkg::i2c_evt_t evt = '0;
  // recorder, mode and protection inputs
  logic [3:0] recordCount = 4'h0;
  logic logFull = 1'b0;
  logic recorderBusy = 1'b0;
  logic eraseBusy = 1'b0;
  logic faultLogMode = 1'b1;
  logic [1:0] protMode = 2'h0;
  logic writePermitPin = 1'b0;
  // design outputs
  logic txValid, wrAck, memRdEn, recordHold, eraseStart, progModeActive, cfgWrStrobe;
  logic [7:0] txData, memData, cfgWrOp, cfgWrData;
  fault_guard_pkg::log_addr_t memAddr;
  // bookkeeping
  int errors = 0;
  int compares = 0;
  int eraseCnt = 0;

  always #20 mclk = ~mclk;

  // erase pulse lasts one cycle, so it is counted as it happens
  always @(posedge mclk) if (eraseStart === 1'b1) eraseCnt <= eraseCnt + 1;

  fault_log_guard u_dut (
    .mclk(mclk), .rst_n(rst_n), .i2cEvt(evt), .txValid(txValid), .txData(txData),
    .wrAck(wrAck), .recordCount(recordCount), .logFull(logFull),
    .recorderBusy(recorderBusy), .eraseBusy(eraseBusy), .memData(memData),
    .memRdEn(memRdEn), .memAddr(memAddr), .recordHold(recordHold),
    .eraseStart(eraseStart), .faultLogMode(faultLogMode), .protMode(protMode),
    .writePermitPin(writePermitPin), .progModeActive(progModeActive),
    .cfgWrStrobe(cfgWrStrobe), .cfgWrOp(cfgWrOp), .cfgWrData(cfgWrData)
  );

  log_mem_model u_mem (.mclk(mclk), .memRdEn(memRdEn), .memAddr(memAddr), .memData(memData));

  // inputs change one ns after the edge so the design sees them settled
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tend(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask

  // one-cycle bus event: 0 start, 1 stop, 2 nack
  task automatic ev(input int k);
    evt.start = (k == 0);
    evt.stop = (k == 1);
    evt.rdNack = (k == 2);
    cyc();
    evt = '0;
  endtask

  // one write byte, every byte is acked whatever it means
  task automatic wrb(input logic [7:0] b);
    evt.wrValid = 1'b1;
    evt.wrData = b;
    cyc();
    evt.wrValid = 1'b0;
    chk({7'h0, wrAck}, 8'h01, "write ack");
  endtask

  // one read byte; a stream may answer late, so the wait is bounded
  task automatic rd(input logic [7:0] exp, input string what);
    int n;
    n = 0;
    evt.rdReq = 1'b1;
    cyc();
    evt.rdReq = 1'b0;
    while (txValid !== 1'b1 && n < 400) begin
      cyc();
      n++;
    end
    if (n == 400) begin
      errors++;
      $display("mismatch at %0t: no read answer", $time);
      test_done();
    end
    chk(txData, exp, what);
  endtask

  // write, repeated start, one read, nack, stop
  task automatic unlock(input logic [7:0] key, input logic [7:0] exp);
    ev(0);
    wrb(fault_guard_pkg::OP_UNLOCK);
    wrb(key);
    ev(0);
    rd(exp, "fault status");
    ev(2);
    ev(1);
  endtask

  // opcode with n key bytes, high byte first
  task automatic wcmd(input logic [7:0] op, input logic [15:0] k, input int n);
    ev(0);
    wrb(op);
    if (n == 2) wrb(k[15:8]);
    if (n >= 1) wrb(k[7:0]);
    ev(1);
    cyc(2);
  endtask

  task automatic status(input logic [3:0] cnt, input logic full);
    recordCount = cnt;
    logFull = full;
    ev(0);
    wrb(fault_guard_pkg::OP_STATUS);
    ev(0);
    rd({cnt, full, 3'h0}, "monitor status");
    ev(2);
    ev(1);
  endtask

  // one config byte; strobe only when permitted, opcode and data checked only then
  task automatic wcfg(input logic [7:0] op, input logic ok);
    ev(0);
    wrb(op);
    wrb(op ^ 8'h3c);
    chk({7'h0, cfgWrStrobe}, {7'h0, ok}, "config strobe");
    if (ok) chk(cfgWrOp, op, "config opcode");
    if (ok) chk(cfgWrData, op ^ 8'h3c, "config data");
    ev(1);
  endtask

  initial begin
    int r;
    int b;
    int n;
    logic ok;
    cyc(2);
    rst_n = 1'b1;
    // permit synchroniser needs a few edges before use
    cyc(3);
    chk({recordHold, progModeActive, txValid, cfgWrStrobe, 4'h0}, 8'h00, "reset outputs");
    tend("reset");

    status(4'h0, 1'b0);
    status(4'h9, 1'b0);
    status(4'hf, 1'b1);
    tend("status");

    // grant waits for both busy sources
    recorderBusy = 1'b1;
    eraseBusy = 1'b1;
    unlock(fault_guard_pkg::KEY_UNLOCK, 8'hc0);
    chk({7'h0, recordHold}, 8'h01, "recording held");
    recorderBusy = 1'b0;
    unlock(fault_guard_pkg::KEY_UNLOCK, 8'hc0);
    eraseBusy = 1'b0;
    cyc(2);
    unlock(fault_guard_pkg::KEY_UNLOCK, 8'hf0);
    tend("unlock");

    // full log with the host stalled until the buffer refuses
    ev(0);
    wrb(fault_guard_pkg::OP_READ_ALL);
    ev(0);
    cyc(100);
    for (r = 0; r < 16; r++) begin
      for (b = 0; b < 7; b++) begin
        rd({1'b0, r[3:0], b[2:0]} ^ 8'h5a, "log byte");
      end
    end
    // a request past the last record gets no answer
    evt.rdReq = 1'b1;
    cyc();
    evt.rdReq = 1'b0;
    n = 0;
    repeat (30) begin
      if (txValid === 1'b1) n++;
      cyc();
    end
    chk(n[7:0], 8'h00, "read past end");
    ev(2);
    ev(1);
    cyc();
    chk({1'b0, memAddr}, 8'h00, "address after stop");
    tend("stream");

    wcmd(fault_guard_pkg::OP_ERASE, 16'h0, 0);
    chk(eraseCnt[7:0], 8'h00, "erase outside program mode");
    wcmd(fault_guard_pkg::OP_PROGRAM, 16'he53e, 2);
    chk({7'h0, progModeActive}, 8'h00, "bad program key");
    // protection must not block the program entry
    protMode = fault_guard_pkg::PROT_LOCKED;
    wcmd(fault_guard_pkg::OP_PROGRAM, 16'he53d, 2);
    chk({7'h0, progModeActive}, 8'h01, "program mode");
    wcmd(fault_guard_pkg::OP_ERASE, 16'h0, 0);
    chk(eraseCnt[7:0], 8'h01, "erase pulse");
    unlock(8'h55, 8'h00);
    chk({7'h0, recordHold}, 8'h00, "recording resumed");
    // still in program mode but relocked, so erase must be ignored
    wcmd(fault_guard_pkg::OP_ERASE, 16'h0, 0);
    chk(eraseCnt[7:0], 8'h01, "erase while relocked");
    wcmd(fault_guard_pkg::OP_USER, 16'h0, 0);
    chk({7'h0, progModeActive}, 8'h00, "user mode");
    tend("erase");

    // no unlock outside fault logging mode
    faultLogMode = 1'b0;
    unlock(fault_guard_pkg::KEY_UNLOCK, 8'h00);
    chk({7'h0, recordHold}, 8'h00, "hold outside logging");
    faultLogMode = 1'b1;
    tend("logging mode");

    // every mode with the pin low and high, pin spanning the write
    for (r = 0; r < 4; r++) begin
      for (b = 0; b < 2; b++) begin
        protMode = r[1:0];
        writePermitPin = b[0];
        cyc(3);
        ok = (r == 0) || (r == 2 && b == 1);
        for (n = 0; n < 3; n++) begin
          wcfg(n == 0 ? fault_guard_pkg::OP_CFG_WRITE : n == 1 ?
            fault_guard_pkg::OP_CFG_MASKED : fault_guard_pkg::OP_TRIM_SET, ok);
        end
      end
    end
    writePermitPin = 1'b0;
    protMode = fault_guard_pkg::PROT_OPEN;
    tend("protection");
    test_done();
  end
endmodule
